// ==== core/net_regs_pkg.sv ====
// package: offsets, field positions, reset values and carriers of the network register bank
package net_regs_pkg;
   localparam logic [11:0] NETWORK_STATUS_OFS = 12'h448;
   localparam logic [11:0] NETWORK_CONTROL_OFS = 12'h44c;
   localparam logic [11:0] LAST_STATION_NUMBER_OFS = 12'h494;
   // control register fields
   localparam int CTL_START_BIT = 8;
   localparam int CTL_RUN_BIT = 9;
   localparam int CTL_CALL_BIT = 10;
   localparam int CTL_BREAK_BIT = 11;
   localparam int CTL_OOC_BIT = 12;
   localparam int CTL_NSF_BIT = 13;
   localparam int CTL_LONG_BIT = 14;
   localparam int CTL_MON_BIT = 15;
   // status register fields
   localparam int ST_MISMATCH_BIT = 4;
   localparam int ST_MISSING_BIT = 5;
   localparam int ST_MAIL_RX_BIT = 6;
   localparam int ST_MAIL_ERR_BIT = 7;
   localparam int ST_RESIZE_BIT = 8;
   localparam int ST_JAM_BIT = 9;
   localparam int ST_BREAK_BIT = 10;
   localparam int ST_RENEW_BIT = 11;
   localparam int ST_LGOOD_BIT = 12;
   localparam int ST_LBAD_BIT = 13;
   localparam int ST_NEW_BIT = 14;
   localparam int ST_LOSS_BIT = 15;
   localparam logic [15:0] STATUS_RST = 16'h0030;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [5:0] FINAL_STATION_RST = 6'h3f;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // live network state delivered by the protocol engine
   typedef struct packed {
      logic [6:0] slot_timer_value;
      logic running;
      logic run_phase;
      logic call_phase;
      logic break_phase_flag;
      logic stop_out_of_cycle;
      logic stop_no_station;
      logic long_frame_flag;
      logic [5:0] final_station_field;
   } engine_state_t;

   // one-cycle event pulses and levels from the engine
   typedef struct packed {
      logic status_point;
      logic mail_rx_done;
      logic mail_rx_all_clear;
      logic mail_err;
      logic mail_err_all_clear;
      logic resize_overlap;
      logic jammer;
      logic break_rx;
      logic renewal_change;
      logic renewal_clear;
      logic renewal_freeze;
      logic link_freeze;
   } engine_events_t;
endpackage

// ==== core/network_control_status_regs.sv ====
// network control, status and final station registers behind a classic wishbone slave
// Behaviour
// - station time readable in control bits 0-6
// - writing start one starts network, reads running
// - writing start zero while running stops network
// - bits 9-11 show run, call, break phase
// - stop cause bits, cleared by start write
// - bit 14 shows long frame option
// - monitor bit settable only while start zero, cleared by writing zero at any time
// - status bits 0-3 drive output pins
// - pin bits kept if data bits 8-10 set
// - bit 4: member flags differ from group
// - bit 5: grouped member flag missing
// - bit 6: mail received, cleared both receive clear
// - bit 7: mail send error, cleared error clear
// - bit 8 resize overlap, write one clears
// - bit 9 jammer detect, write one clears
// - bit 10 break detect, write one clears
// - bit 11 data renewal, frozen during trigger
// - bit 12 link group good, frozen triggers
// - bit 13 grouped link flag zero
// - bits 14/15 member rise and fall
// - final station read-only, resets to ones; read live from engine_state_in.final_station_field, no reset held here
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module network_control_status_regs
   import net_regs_pkg::*;
#(
   parameter int STATIONS = 64
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [11:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire engine_state_t engine_state_in,
   input wire engine_events_t engine_events_in,
   input wire logic [STATIONS-1:0] member_flags_in,
   input wire logic [STATIONS-1:0] member_group_mask_in,
   input wire logic [STATIONS-1:0] link_flags_in,
   input wire logic [STATIONS-1:0] link_group_mask_in,
   output logic start_request_out,
   output logic stop_request_out,
   output logic memory_monitor_mode_out,
   output logic [3:0] general_output_bits_out
);
   logic req;
   logic wr;
   logic wr_ctl;
   logic wr_st;
   logic lo_lane;
   logic hi_lane;
   logic start_one;
   logic start_zero;
   logic link_all_good;
   logic [15:0] ctl_view;
   logic [15:0] st_view;
   logic [15:0] status_r;
   logic mon_r;
   logic [STATIONS-1:0] member_prev_r;
   logic [31:0] rd_nxt;

   // single-cycle answer: ack one cycle after the strobe, never twice in a row
   assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr = req && wb_we_in;
   assign wr_ctl = wr && (wb_adr_in == NETWORK_CONTROL_OFS);
   assign wr_st = wr && (wb_adr_in == NETWORK_STATUS_OFS);
   assign lo_lane = wb_sel_in[0];
   assign hi_lane = wb_sel_in[1];
   assign start_one = wr_ctl && hi_lane && wb_dat_in[CTL_START_BIT];
   assign start_zero = wr_ctl && hi_lane && !wb_dat_in[CTL_START_BIT];
   assign link_all_good = ((link_flags_in & link_group_mask_in) == link_group_mask_in);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req;
      end
   end

   // start and stop are one-cycle requests to the engine; start clears stop causes there
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         start_request_out <= 1'b0;
         stop_request_out <= 1'b0;
      end else begin
         start_request_out <= start_one;
         stop_request_out <= start_zero && engine_state_in.running;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mon_r <= 1'b0;
      end else if (wr_ctl && hi_lane) begin
         if (!wb_dat_in[CTL_MON_BIT]) begin
            mon_r <= 1'b0;
         end else if (!engine_state_in.running) begin
            mon_r <= 1'b1;
         end
      end
   end
   assign memory_monitor_mode_out = mon_r;

   // stop-cause flags come from the engine, which drops them on start or reset
   always_comb begin
      ctl_view = CONTROL_RST;
      ctl_view[6:0] = engine_state_in.slot_timer_value;
      ctl_view[CTL_START_BIT] = engine_state_in.running;
      ctl_view[CTL_RUN_BIT] = engine_state_in.run_phase;
      ctl_view[CTL_CALL_BIT] = engine_state_in.call_phase;
      ctl_view[CTL_BREAK_BIT] = engine_state_in.break_phase_flag;
      ctl_view[CTL_OOC_BIT] = engine_state_in.stop_out_of_cycle;
      ctl_view[CTL_NSF_BIT] = engine_state_in.stop_no_station;
      ctl_view[CTL_LONG_BIT] = engine_state_in.long_frame_flag;
      ctl_view[CTL_MON_BIT] = mon_r;
   end

   // pins and write-one-to-clear flags
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_r[3:0] <= STATUS_RST[3:0];
      end else if (wr_st && lo_lane) begin
         if (!(hi_lane && (wb_dat_in[10:8] != 3'h0))) begin
            status_r[3:0] <= wb_dat_in[3:0];
         end
      end
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_w1c
         logic ev;
         assign ev = (i == 0) ? engine_events_in.resize_overlap :
                     (i == 1) ? engine_events_in.jammer : engine_events_in.break_rx;
         // event wins over a simultaneous clear
         always_ff @(posedge mclk_in) begin
            if (rst_in) begin
               status_r[ST_RESIZE_BIT+i] <= STATUS_RST[ST_RESIZE_BIT+i];
            end else if (ev) begin
               status_r[ST_RESIZE_BIT+i] <= 1'b1;
            end else if (wr_st && hi_lane && wb_dat_in[ST_RESIZE_BIT+i]) begin
               status_r[ST_RESIZE_BIT+i] <= 1'b0;
            end
         end
      end
   endgenerate

   // mail summaries
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_r[ST_MAIL_RX_BIT] <= STATUS_RST[ST_MAIL_RX_BIT];
         status_r[ST_MAIL_ERR_BIT] <= STATUS_RST[ST_MAIL_ERR_BIT];
      end else begin
         if (engine_events_in.mail_rx_done) begin
            status_r[ST_MAIL_RX_BIT] <= 1'b1;
         end else if (engine_events_in.mail_rx_all_clear) begin
            status_r[ST_MAIL_RX_BIT] <= 1'b0;
         end
         if (engine_events_in.mail_err) begin
            status_r[ST_MAIL_ERR_BIT] <= 1'b1;
         end else if (engine_events_in.mail_err_all_clear) begin
            status_r[ST_MAIL_ERR_BIT] <= 1'b0;
         end
      end
   end

   // renewal flag, held still while its trigger is out
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_r[ST_RENEW_BIT] <= STATUS_RST[ST_RENEW_BIT];
      end else if (!engine_events_in.renewal_freeze) begin
         if (engine_events_in.renewal_change) begin
            status_r[ST_RENEW_BIT] <= 1'b1;
         end else if (engine_events_in.renewal_clear) begin
            status_r[ST_RENEW_BIT] <= 1'b0;
         end
      end
   end

   // link good, held while link_freeze: set when all grouped links are up, else cleared at the status point
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_r[ST_LGOOD_BIT] <= STATUS_RST[ST_LGOOD_BIT];
      end else if (!engine_events_in.link_freeze) begin
         if (link_all_good) begin
            status_r[ST_LGOOD_BIT] <= 1'b1;
         end else if (engine_events_in.status_point) begin
            status_r[ST_LGOOD_BIT] <= 1'b0;
         end
      end
   end

   // comparisons sampled at the status-management point
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_r[ST_MISMATCH_BIT] <= STATUS_RST[ST_MISMATCH_BIT];
         status_r[ST_MISSING_BIT] <= STATUS_RST[ST_MISSING_BIT];
         status_r[ST_LBAD_BIT] <= STATUS_RST[ST_LBAD_BIT];
         status_r[ST_NEW_BIT] <= STATUS_RST[ST_NEW_BIT];
         status_r[ST_LOSS_BIT] <= STATUS_RST[ST_LOSS_BIT];
         member_prev_r <= '0;
      end else if (engine_events_in.status_point) begin
         status_r[ST_MISMATCH_BIT] <= (member_flags_in != member_group_mask_in);
         status_r[ST_MISSING_BIT] <= |(member_group_mask_in & ~member_flags_in);
         status_r[ST_LBAD_BIT] <= |(link_group_mask_in & ~link_flags_in);
         status_r[ST_NEW_BIT] <= |(member_flags_in & ~member_prev_r);
         status_r[ST_LOSS_BIT] <= |(~member_flags_in & member_prev_r);
         member_prev_r <= member_flags_in;
      end
   end

   assign st_view = status_r;
   assign general_output_bits_out = status_r[3:0];

   always_comb begin
      rd_nxt = UNMAPPED_READ;
      unique case (wb_adr_in)
         NETWORK_CONTROL_OFS: rd_nxt = {16'h0000, ctl_view};
         NETWORK_STATUS_OFS: rd_nxt = {16'h0000, st_view};
         LAST_STATION_NUMBER_OFS: rd_nxt = {26'h0000000, engine_state_in.final_station_field};
         default: rd_nxt = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (req && !wb_we_in) begin
         wb_dat_out <= rd_nxt;
      end
   end

   sequence s_ctl_write_start;
      wr_ctl && hi_lane && wb_dat_in[CTL_START_BIT];
   endsequence

   chk_start_request_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_write_start |=> start_request_out)
      else $error("start write gave no start request");
   chk_stop_only_running: assert property (@(posedge mclk_in) disable iff (rst_in)
      stop_request_out |-> $past(engine_state_in.running))
      else $error("stop request while not running");
   chk_monitor_locked: assert property (@(posedge mclk_in) disable iff (rst_in)
      (engine_state_in.running && !mon_r) |=> !mon_r)
      else $error("monitor bit set while running");
   chk_pins_guarded: assert property (@(posedge mclk_in) disable iff (rst_in)
      (wr_st && hi_lane && wb_dat_in[10:8] != 3'h0) |=> $stable(general_output_bits_out))
      else $error("pin bits changed under guard");
   chk_jam_event_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.jammer |=> status_r[ST_JAM_BIT])
      else $error("jammer flag not set");
   chk_resize_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      (wr_st && hi_lane && wb_dat_in[ST_RESIZE_BIT] && !engine_events_in.resize_overlap)
      |=> !status_r[ST_RESIZE_BIT])
      else $error("resize flag not cleared");
   chk_renew_frozen: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.renewal_freeze |=> $stable(status_r[ST_RENEW_BIT]))
      else $error("renewal flag moved while frozen");
   chk_link_bad_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.status_point |=>
      status_r[ST_LBAD_BIT] == $past(|(link_group_mask_in & ~link_flags_in)))
      else $error("link bad flag wrong");
   chk_mismatch_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.status_point |=>
      status_r[ST_MISMATCH_BIT] == $past(member_flags_in != member_group_mask_in))
      else $error("member mismatch flag wrong");
   chk_ack_one_cycle: assert property (@(posedge mclk_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held more than one cycle");

   // read checks compare against the engine view of the taking edge, since the
   // read word is registered and the engine keeps moving underneath it
   sequence s_ctl_read;
      req && !wb_we_in && (wb_adr_in == NETWORK_CONTROL_OFS);
   endsequence

   sequence s_final_read;
      req && !wb_we_in && (wb_adr_in == LAST_STATION_NUMBER_OFS);
   endsequence

   sequence s_ctl_write_stop;
      wr_ctl && hi_lane && !wb_dat_in[CTL_START_BIT] && engine_state_in.running;
   endsequence

   sequence s_pin_write_open;
      wr_st && lo_lane && !(hi_lane && (wb_dat_in[10:8] != 3'h0));
   endsequence

   sequence s_status_sample;
      engine_events_in.status_point;
   endsequence

   chk_time_read: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_read |=> wb_dat_out[6:0] == $past(engine_state_in.slot_timer_value))
      else $error("station time read wrong");
   chk_no_stray_start: assert property (@(posedge mclk_in) disable iff (rst_in)
      !(wr_ctl && hi_lane && wb_dat_in[CTL_START_BIT]) |=> !start_request_out)
      else $error("start request without start write");
   chk_stop_request_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_write_stop |=> stop_request_out)
      else $error("stop write gave no stop request");
   chk_phase_read: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_read |=> wb_dat_out[11:9] == $past({engine_state_in.break_phase_flag,
         engine_state_in.call_phase, engine_state_in.run_phase}))
      else $error("phase bits read wrong");
   chk_stop_cause_read: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_read |=> wb_dat_out[13:12] == $past({engine_state_in.stop_no_station,
         engine_state_in.stop_out_of_cycle}))
      else $error("stop cause bits read wrong");
   chk_long_read: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_read |=> wb_dat_out[CTL_LONG_BIT] == $past(engine_state_in.long_frame_flag))
      else $error("long frame bit read wrong");
   chk_monitor_set: assert property (@(posedge mclk_in) disable iff (rst_in)
      (wr_ctl && hi_lane && wb_dat_in[CTL_MON_BIT] && !engine_state_in.running) |=> mon_r)
      else $error("monitor bit not set while stopped");
   chk_pins_written: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_pin_write_open |=> general_output_bits_out == $past(wb_dat_in[3:0]))
      else $error("pin bits not written");
   chk_pins_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
      !(wr_st && lo_lane) |=> $stable(general_output_bits_out))
      else $error("pin bits moved without a write");
   chk_missing_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_status_sample |=>
      status_r[ST_MISSING_BIT] == $past(|(member_group_mask_in & ~member_flags_in)))
      else $error("member missing flag wrong");
   chk_mail_rx_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.mail_rx_done |=> status_r[ST_MAIL_RX_BIT])
      else $error("mail received flag not set");
   chk_mail_rx_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      (engine_events_in.mail_rx_all_clear && !engine_events_in.mail_rx_done)
      |=> !status_r[ST_MAIL_RX_BIT])
      else $error("mail received flag not cleared");
   chk_mail_err_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.mail_err |=> status_r[ST_MAIL_ERR_BIT])
      else $error("mail error flag not set");
   chk_mail_err_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      (engine_events_in.mail_err_all_clear && !engine_events_in.mail_err)
      |=> !status_r[ST_MAIL_ERR_BIT])
      else $error("mail error flag not cleared");
   chk_resize_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.resize_overlap |=> status_r[ST_RESIZE_BIT])
      else $error("resize flag not set");
   chk_jam_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      (wr_st && hi_lane && wb_dat_in[ST_JAM_BIT] && !engine_events_in.jammer)
      |=> !status_r[ST_JAM_BIT])
      else $error("jammer flag not cleared");
   chk_break_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.break_rx |=> status_r[ST_BREAK_BIT])
      else $error("break flag not set");
   chk_break_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
      (wr_st && hi_lane && wb_dat_in[ST_BREAK_BIT] && !engine_events_in.break_rx)
      |=> !status_r[ST_BREAK_BIT])
      else $error("break flag not cleared");
   chk_renew_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      (engine_events_in.renewal_change && !engine_events_in.renewal_freeze)
      |=> status_r[ST_RENEW_BIT])
      else $error("renewal flag not set");
   chk_link_good_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
      (link_all_good && !engine_events_in.link_freeze) |=> status_r[ST_LGOOD_BIT])
      else $error("link good flag not set");
   chk_link_good_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
      (s_status_sample ##0 (!link_all_good && !engine_events_in.link_freeze))
      |=> !status_r[ST_LGOOD_BIT])
      else $error("link good flag not cleared");
   chk_link_good_frozen: assert property (@(posedge mclk_in) disable iff (rst_in)
      engine_events_in.link_freeze |=> $stable(status_r[ST_LGOOD_BIT]))
      else $error("link good flag moved while frozen");
   chk_new_member_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_status_sample |=> status_r[ST_NEW_BIT] == $past(|(member_flags_in & ~member_prev_r)))
      else $error("new member flag wrong");
   chk_loss_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_status_sample |=> status_r[ST_LOSS_BIT] == $past(|(~member_flags_in & member_prev_r)))
      else $error("member loss flag wrong");
   chk_final_read: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_final_read |=> wb_dat_out == {26'h0000000, $past(engine_state_in.final_station_field)})
      else $error("final station read wrong");
   chk_control_spare_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_ctl_read |=> (wb_dat_out[7] == 1'b0) && (wb_dat_out[31:16] == 16'h0000))
      else $error("control spare bits not zero");
endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
// wishbone master standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk_in,
   input wire logic ack_in,
   input wire logic [31:0] dat_in,
   output logic cyc_out,
   output logic stb_out,
   output logic we_out,
   output logic [11:0] adr_out,
   output logic [3:0] sel_out,
   output logic [31:0] dat_out
);
   logic hung;
   initial begin
      {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out, hung} = '0;
   end
   // request held until ack is seen at an edge or 50 edges pass; then released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_in);
      {cyc_out, stb_out} <= 2'b11;
      we_out <= w;
      adr_out <= a;
      sel_out <= s;
      dat_out <= d;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack_in !== 1'b1 && n < 50);
      if (n >= 50) hung = 1'b1;
      q = dat_in;
      {cyc_out, stb_out} <= 2'b00;
      // released data must not keep showing the written value
      dat_out <= ~d;
   endtask
endmodule
`default_nettype wire

// ==== testbench/network_control_status_regs_bench.sv ====
// bench: host model, engine stimulus and a scoreboard for the register bank
`timescale 1ns/1ps
`default_nettype none
module network_control_status_regs_bench;
   import net_regs_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cyc, stb, we, ack, sreq, preq, mon, mon_x;
   logic [11:0] adr;
   logic [3:0] sel, pins;
   logic [31:0] wdat, rdat, q, st;
   logic [63:0] mf, mg, prev, a, b, lf, lg;
   engine_state_t es;
   engine_events_t ev;
   int failures = 0, checked = 0, seed = 41051, starts = 0, stops = 0;

   network_control_status_regs #(.STATIONS(64)) dut_u (
      .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .engine_state_in(es),
      .engine_events_in(ev), .member_flags_in(mf), .member_group_mask_in(mg),
      .link_flags_in(lf), .link_group_mask_in(lg),
      .start_request_out(sreq), .stop_request_out(preq),
      .memory_monitor_mode_out(mon), .general_output_bits_out(pins));
   host_model host_u (.clk_in(mclk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
      .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));

   initial forever #2 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      if (sreq === 1'b1) starts++;
      if (preq === 1'b1) stops++;
   end

   task automatic results();
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] ad, input logic [3:0] s, input logic [31:0] d);
      host_u.xfer(1'b1, ad, s, d, q);
      if (host_u.hung) begin
         failures++;
         results();
      end
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] e, input string nm);
      host_u.xfer(1'b0, ad, 4'hf, 32'h0, q);
      if (host_u.hung) begin
         failures++;
         results();
      end
      check(nm, e, q);
   endtask
   // mask bits: 800 point, 400 rx, 200 rx clr, 100 err, 080 err clr, 040 resize,
   // 020 jam, 010 break, 008 renew, 004 renew clr, 002/001 freezes held as levels
   task automatic pulse(input logic [11:0] m);
      @(posedge mclk_in);
      ev <= engine_events_t'(m);
      @(posedge mclk_in);
      ev <= engine_events_t'(m & 12'h003);
   endtask
   function automatic logic [31:0] ctl_exp();
      return {16'h0, mon_x, es.long_frame_flag, es.stop_no_station, es.stop_out_of_cycle,
         es.break_phase_flag, es.call_phase, es.run_phase, es.running, 1'b0,
         es.slot_timer_value};
   endfunction

   initial begin
      es = '0;
      es.final_station_field = 6'h3f;
      ev = '0;
      mf = '0;
      mg = '0;
      lf = '0;
      lg = 64'h1;
      prev = '0;
      st = 32'h30;
      mon_x = 1'b0;
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      rd(NETWORK_STATUS_OFS, st, "status");
      rd(NETWORK_CONTROL_OFS, 32'h0, "control");
      rd(LAST_STATION_NUMBER_OFS, 32'h3f, "final");
      rd(12'h450, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk_in);
         es <= engine_state_t'(20'($random(seed)));
         wr(LAST_STATION_NUMBER_OFS, 4'h3, $random(seed));
         rd(NETWORK_CONTROL_OFS, ctl_exp(), "control");
         rd(LAST_STATION_NUMBER_OFS, {26'h0, es.final_station_field}, "final");
      end
      @(posedge mclk_in);
      es.running <= 1'b1;
      starts = 0;
      stops = 0;
      wr(NETWORK_CONTROL_OFS, 4'h3, 32'h8100);
      wr(NETWORK_CONTROL_OFS, 4'h3, 32'h0000);
      @(posedge mclk_in);
      check("start pulses", 1, starts);
      check("stop pulses", 1, stops);
      check("monitor", 0, mon);
      es.running <= 1'b0;
      wr(NETWORK_CONTROL_OFS, 4'h3, 32'h8000);
      mon_x = 1'b1;
      rd(NETWORK_CONTROL_OFS, ctl_exp(), "control");
      check("monitor", 1, mon);
      wr(NETWORK_CONTROL_OFS, 4'h3, 32'h0080);
      mon_x = 1'b0;
      rd(NETWORK_CONTROL_OFS, ctl_exp(), "control");
      check("stop pulses", 1, stops);
      wr(NETWORK_STATUS_OFS, 4'h1, 32'h5);
      check("pins", 5, pins);
      pulse(12'h070);
      st = 32'h735;
      rd(NETWORK_STATUS_OFS, st, "status");
      wr(NETWORK_STATUS_OFS, 4'h3, 32'h050a);
      st = 32'h235;
      rd(NETWORK_STATUS_OFS, st, "status");
      wr(NETWORK_STATUS_OFS, 4'h3, 32'h020c);
      wr(NETWORK_STATUS_OFS, 4'h3, 32'h000c);
      st = 32'h3c;
      rd(NETWORK_STATUS_OFS, st, "status");
      pulse(12'h500);
      rd(NETWORK_STATUS_OFS, st | 32'hc0, "status");
      pulse(12'h280);
      rd(NETWORK_STATUS_OFS, st, "status");
      pulse(12'h00a);
      pulse(12'h000);
      rd(NETWORK_STATUS_OFS, st, "status");
      pulse(12'h008);
      rd(NETWORK_STATUS_OFS, st | 32'h800, "status");
      pulse(12'h004);
      for (int i = 0; i < 4; i++) begin
         a = {$random(seed), $random(seed)};
         b = (i == 1) ? a : {$random(seed), $random(seed)};
         @(posedge mclk_in);
         mf <= a;
         mg <= b;
         pulse(12'h800);
         st = (st & 32'h0fcf) | 32'h2000 | ((a != b) << 4) | ((|(b & ~a)) << 5)
            | ((|(a & ~prev)) << 14) | ((|(prev & ~a)) << 15);
         prev = a;
         rd(NETWORK_STATUS_OFS, st, "status");
      end
      @(posedge mclk_in);
      lf <= 64'h1;
      rd(NETWORK_STATUS_OFS, st | 32'h1000, "status");
      @(posedge mclk_in);
      lf <= 64'h0;
      pulse(12'h800);
      st = (st & 32'h0fcf) | 32'h2000 | ((a != b) << 4) | ((|(b & ~a)) << 5);
      rd(NETWORK_STATUS_OFS, st, "status");
      results();
   end
endmodule
`default_nettype wire
